// [common/cts_pkg.sv]
// Register map, field positions and reset values of the capacitive touch scan block.
package cts_pkg;

    localparam int unsigned CTS_AW = 4;
    localparam int unsigned CTS_DW = 8;

    localparam logic [3:0] CTS_OFS_SLOT_PRELOAD = 4'h0;
    localparam logic [3:0] CTS_OFS_FUNC_CTRL    = 4'h1;
    localparam logic [3:0] CTS_OFS_FREQ_CTRL    = 4'h2;
    localparam logic [3:0] CTS_OFS_FUNC_LO      = 4'h3;
    localparam logic [3:0] CTS_OFS_FUNC_HI      = 4'h4;
    localparam logic [3:0] CTS_OFS_SENSE_LO     = 4'h5;
    localparam logic [3:0] CTS_OFS_SENSE_HI     = 4'h6;
    localparam logic [3:0] CTS_OFS_REFCAP_LO    = 4'h7;
    localparam logic [3:0] CTS_OFS_REFCAP_HI    = 4'h8;
    localparam logic [3:0] CTS_OFS_MOD_CTRL0    = 4'h9;
    localparam logic [3:0] CTS_OFS_MOD_CTRL1    = 4'ha;

    // Function control register fields.
    localparam int unsigned CTS_B_SLOT_OVF  = 6;
    localparam int unsigned CTS_B_START     = 5;
    localparam int unsigned CTS_B_SENSE_OVF = 4;
    localparam int unsigned CTS_B_FUNC_OVF  = 3;
    localparam int unsigned CTS_B_FCLK_LSB  = 0;

    // Module control register 0 fields.
    localparam int unsigned CTS_B_MUX_LSB   = 6;
    localparam int unsigned CTS_B_DOUBLE    = 5;
    localparam int unsigned CTS_B_FILTER    = 4;
    localparam int unsigned CTS_B_HOP_CTRL  = 3;
    localparam int unsigned CTS_B_HOP_LSB   = 0;

    // Module control register 1 fields.
    localparam int unsigned CTS_B_SLOT_CLK  = 7;
    localparam int unsigned CTS_B_REF_EN    = 5;
    localparam int unsigned CTS_B_SENSE_EN  = 4;
    localparam int unsigned CTS_B_KEY_LSB   = 0;
    localparam logic [7:0]  CTS_MOD_CTRL1_MASK = 8'hbf;

    localparam logic [7:0]  CTS_RST_PRELOAD   = 8'h00;
    localparam logic [1:0]  CTS_RST_FREQ_SEL  = 2'h3;
    localparam logic [9:0]  CTS_RST_REFCAP    = 10'h000;
    localparam logic [7:0]  CTS_RST_MOD_CTRL  = 8'h00;

    // Function counter clock select codes.
    localparam logic [1:0]  CTS_FCLK_DIV1 = 2'h0;
    localparam logic [1:0]  CTS_FCLK_DIV2 = 2'h1;
    localparam logic [1:0]  CTS_FCLK_DIV4 = 2'h2;
    localparam logic [1:0]  CTS_FCLK_DIV8 = 2'h3;

    // A time-slot unit ends at this count, so it spans 32 time-slot clock periods.
    localparam logic [4:0]  CTS_UNIT_LAST = 5'h1f;
    localparam logic [7:0]  CTS_SLOT_LAST = 8'hff;
    localparam int unsigned CTS_KEYS      = 4;

endpackage

// [verilog/cts_sync3.sv]
// Three-stage synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
module cts_sync3 #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
    } cts_sync_t;

    cts_sync_t st_ff;
    cts_sync_t nxt_st;

    // A change is taken only when stages two and three agree, so a sample caught
    // mid-transition can never reach the counters.
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.s1   = i_async;
        nxt_st.s2   = st_ff.s1;
        nxt_st.s3   = st_ff.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_ff.s2[i] == st_ff.s3[i])
            begin
                nxt_st.lvl[i] = st_ff.s3[i];
            end
            nxt_st.rise[i] = (st_ff.s2[i] == st_ff.s3[i]) && st_ff.s3[i] && !st_ff.lvl[i];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_level = st_ff.lvl;
    assign o_rise  = st_ff.rise;

endmodule

// [verilog/cts_scan.sv]
// Capacitive touch scan core: registers, time-slot window and the two counters.
//
// Summary of operation
// - Two-bit field selects oscillator frequency 1, 3, 7 or 11 MHz.
// - Function counter stops and holds on slot overflow; read as byte pair.
// - Sense-cycle counter stops and holds on slot overflow; read as byte pair.
// - Sense-cycle count clears to zero when scan start is written low.
// - Ten-bit reference capacitor code, low byte plus two high bits.
// - Mux field codes 0 to 3 route sense inputs 1 to 4.
// - Doubling bit set runs key oscillator at twice its selected frequency.
// - Filter enable is module control 0 bit 4, reset disabled.
// - Hop control select one hands hopping to hardware, ignoring hop field.
// - Three-bit hop field picks eight frequencies, used only when select is 0.
// - Slot clock is reference oscillator when 0, system clock over four when 1.
// - Module control 1 bits 0 to 3 enable inputs; only enabled inputs scan.
// - Start low clears sense, function and unit counters, not slot counter.
// - Start rising switches on all four counters and the enabled oscillators.
// - Slot overflow stops both oscillators and all four counters.
// - One touch interrupt, only on slot counter overflow.
// - Sense count overflow flag sets on overflow, stays until software clears.
// - Function count overflow flag sets on overflow, never auto-cleared.
// - Slot overflow sets slot flag and requests an interrupt at once.
// - Count selected sense oscillator cycles during the fixed window.
// - Window lasts 256 minus preload units of 32 slot clock periods.
// - Function clock select picks system clock divided by 1, 2, 4 or 8.
// - Software write of 1 cannot set slot flag; software only clears it.
// - Function counter runs only on system slot clock or enabled reference.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module cts_scan
    import cts_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic [CTS_AW-1:0]    i_addr,
    input  wire logic [CTS_DW-1:0]    i_wr_data,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    input  wire logic                 i_ref_osc,
    input  wire logic [CTS_KEYS-1:0]  i_sense_osc,
    output logic      [CTS_DW-1:0]    o_rd_data,
    output logic                      o_touch_irq,
    output logic                      o_ref_osc_run,
    output logic                      o_sense_osc_run,
    output logic      [1:0]           o_osc_freq_select,
    output logic                      o_freq_double_enable,
    output logic                      o_filter_enable,
    output logic                      o_hop_control_select,
    output logic      [2:0]           o_hop_freq_select,
    output logic      [1:0]           o_input_mux_select,
    output logic      [9:0]           o_ref_cap_code
);

    typedef struct packed {
        logic [7:0]  slot_preload;
        logic        slot_overflow_flag;
        logic        scan_start;
        logic        sense_count_overflow_flag;
        logic        function_count_overflow_flag;
        logic [1:0]  function_count_clock_select;
        logic [1:0]  oscillator_freq_select;
        logic [15:0] func_cnt;
        logic [15:0] sense_cnt;
        logic [9:0]  ref_cap_code;
        logic [7:0]  mod_ctrl0;
        logic [7:0]  mod_ctrl1;
        logic        running;
        logic [4:0]  unit_cnt;
        logic [7:0]  slot_cnt;
        logic [2:0]  div_cnt;
        logic        touch_irq_request;
        logic        ref_run;
        logic        sense_run;
        logic [7:0]  rd_data;
    } cts_state_t;

    cts_state_t st_ff;
    cts_state_t nxt_st;

    logic [CTS_KEYS:0] osc_rise;

    cts_sync3 #(
        .W (CTS_KEYS + 1)
    ) u_osc_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_sense_osc, i_ref_osc}),
        .o_level (),
        .o_rise  (osc_rise)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded controls.

    logic       slot_clk_sys;
    logic       ref_en;
    logic       sense_en;
    logic [1:0] mux_sel;
    logic       key_en;
    logic       slot_tick;
    logic       func_tick;
    logic       sense_tick;
    logic       slot_ovf;
    logic       wr_ctrl;
    logic       start_low_wr;
    logic       start_rise_wr;

    always_comb
    begin
        slot_clk_sys = st_ff.mod_ctrl1[CTS_B_SLOT_CLK];
        ref_en       = st_ff.mod_ctrl1[CTS_B_REF_EN];
        sense_en     = st_ff.mod_ctrl1[CTS_B_SENSE_EN];
        mux_sel      = st_ff.mod_ctrl0[CTS_B_MUX_LSB +: 2];
        key_en       = st_ff.mod_ctrl1[CTS_B_KEY_LSB + 32'(mux_sel)];
        // The reference oscillator is stopped while disabled, so its edges are ignored.
        slot_tick    = st_ff.running && (slot_clk_sys ? (st_ff.div_cnt[1:0] == 2'h3)
                                                      : (ref_en && osc_rise[0]));
        case (st_ff.function_count_clock_select)
            CTS_FCLK_DIV1: func_tick = 1'b1;
            CTS_FCLK_DIV2: func_tick = st_ff.div_cnt[0];
            CTS_FCLK_DIV4: func_tick = (st_ff.div_cnt[1:0] == 2'h3);
            CTS_FCLK_DIV8: func_tick = (st_ff.div_cnt == 3'h7);
            default:       func_tick = 1'b0;
        endcase
        func_tick    = func_tick && st_ff.running && (slot_clk_sys || ref_en);
        sense_tick   = st_ff.running && sense_en && key_en
                       && osc_rise[32'(mux_sel) + 1];
        slot_ovf     = slot_tick && (st_ff.unit_cnt == CTS_UNIT_LAST)
                       && (st_ff.slot_cnt == CTS_SLOT_LAST);
        wr_ctrl      = i_wr && (i_addr == CTS_OFS_FUNC_CTRL);
        start_low_wr  = wr_ctrl && !i_wr_data[CTS_B_START];
        start_rise_wr = wr_ctrl && i_wr_data[CTS_B_START] && !st_ff.scan_start;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb
    begin
        nxt_st                   = st_ff;
        nxt_st.div_cnt           = st_ff.div_cnt + 3'h1;
        nxt_st.touch_irq_request = 1'b0;
        nxt_st.rd_data           = '0;

        if (slot_tick)
        begin
            nxt_st.unit_cnt = st_ff.unit_cnt + 5'h1;
            if (st_ff.unit_cnt == CTS_UNIT_LAST)
            begin
                nxt_st.slot_cnt = st_ff.slot_cnt + 8'h1;
            end
        end
        if (func_tick)
        begin
            nxt_st.func_cnt = st_ff.func_cnt + 16'h1;
        end
        if (sense_tick)
        begin
            nxt_st.sense_cnt = st_ff.sense_cnt + 16'h1;
        end

        if (i_wr)
        begin
            case (i_addr)
                CTS_OFS_SLOT_PRELOAD: nxt_st.slot_preload = i_wr_data;
                CTS_OFS_FUNC_CTRL:
                begin
                    // Flags only clear from software; writing 1 leaves them as they are.
                    if (!i_wr_data[CTS_B_SLOT_OVF])
                    begin
                        nxt_st.slot_overflow_flag = 1'b0;
                    end
                    if (!i_wr_data[CTS_B_SENSE_OVF])
                    begin
                        nxt_st.sense_count_overflow_flag = 1'b0;
                    end
                    if (!i_wr_data[CTS_B_FUNC_OVF])
                    begin
                        nxt_st.function_count_overflow_flag = 1'b0;
                    end
                    nxt_st.scan_start = i_wr_data[CTS_B_START];
                    nxt_st.function_count_clock_select = i_wr_data[CTS_B_FCLK_LSB +: 2];
                end
                CTS_OFS_FREQ_CTRL:  nxt_st.oscillator_freq_select = i_wr_data[1:0];
                CTS_OFS_REFCAP_LO:  nxt_st.ref_cap_code[7:0] = i_wr_data;
                CTS_OFS_REFCAP_HI:  nxt_st.ref_cap_code[9:8] = i_wr_data[1:0];
                CTS_OFS_MOD_CTRL0:  nxt_st.mod_ctrl0 = i_wr_data;
                CTS_OFS_MOD_CTRL1:  nxt_st.mod_ctrl1 = i_wr_data & CTS_MOD_CTRL1_MASK;
                default:            nxt_st.running = st_ff.running;
            endcase
        end

        if (start_low_wr)
        begin
            // The slot counter is left alone so its last value stays visible.
            nxt_st.sense_cnt = '0;
            nxt_st.func_cnt  = '0;
            nxt_st.unit_cnt  = '0;
            nxt_st.running   = 1'b0;
        end
        else if (start_rise_wr)
        begin
            nxt_st.running  = 1'b1;
            nxt_st.unit_cnt = '0;
            nxt_st.slot_cnt = st_ff.slot_preload;
        end

        // Hardware sets win over a software clear in the same cycle.
        if (func_tick && (st_ff.func_cnt == 16'hffff))
        begin
            nxt_st.function_count_overflow_flag = 1'b1;
        end
        if (sense_tick && (st_ff.sense_cnt == 16'hffff))
        begin
            nxt_st.sense_count_overflow_flag = 1'b1;
        end
        if (slot_ovf)
        begin
            nxt_st.slot_overflow_flag = 1'b1;
            nxt_st.touch_irq_request  = 1'b1;
            nxt_st.running            = 1'b0;
            // A start-low write in the same cycle must still clear the counts.
            if (!start_low_wr)
            begin
                nxt_st.func_cnt  = st_ff.func_cnt;
                nxt_st.sense_cnt = st_ff.sense_cnt;
            end
            // Scan start is not touched here; a new window needs a low then high write.
            nxt_st.scan_start         = start_low_wr ? 1'b0 : nxt_st.scan_start;
        end

        // Registered so that the oscillator enables leave the block glitch-free.
        nxt_st.ref_run   = nxt_st.running && nxt_st.mod_ctrl1[CTS_B_REF_EN];
        nxt_st.sense_run = nxt_st.running && nxt_st.mod_ctrl1[CTS_B_SENSE_EN];

        if (i_rd)
        begin
            case (i_addr)
                CTS_OFS_SLOT_PRELOAD: nxt_st.rd_data = st_ff.slot_preload;
                CTS_OFS_FUNC_CTRL:    nxt_st.rd_data = {1'b0, st_ff.slot_overflow_flag,
                                                        st_ff.scan_start,
                                                        st_ff.sense_count_overflow_flag,
                                                        st_ff.function_count_overflow_flag,
                                                        1'b0,
                                                        st_ff.function_count_clock_select};
                CTS_OFS_FREQ_CTRL:    nxt_st.rd_data = {6'h00, st_ff.oscillator_freq_select};
                CTS_OFS_FUNC_LO:      nxt_st.rd_data = st_ff.func_cnt[7:0];
                CTS_OFS_FUNC_HI:      nxt_st.rd_data = st_ff.func_cnt[15:8];
                CTS_OFS_SENSE_LO:     nxt_st.rd_data = st_ff.sense_cnt[7:0];
                CTS_OFS_SENSE_HI:     nxt_st.rd_data = st_ff.sense_cnt[15:8];
                CTS_OFS_REFCAP_LO:    nxt_st.rd_data = st_ff.ref_cap_code[7:0];
                CTS_OFS_REFCAP_HI:    nxt_st.rd_data = {6'h00, st_ff.ref_cap_code[9:8]};
                CTS_OFS_MOD_CTRL0:    nxt_st.rd_data = st_ff.mod_ctrl0;
                CTS_OFS_MOD_CTRL1:    nxt_st.rd_data = st_ff.mod_ctrl1;
                default:              nxt_st.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ff                        <= '0;
            st_ff.slot_preload           <= CTS_RST_PRELOAD;
            st_ff.oscillator_freq_select <= CTS_RST_FREQ_SEL;
            st_ff.ref_cap_code           <= CTS_RST_REFCAP;
            st_ff.mod_ctrl0              <= CTS_RST_MOD_CTRL;
            st_ff.mod_ctrl1              <= CTS_RST_MOD_CTRL;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from state flops.

    assign o_rd_data            = st_ff.rd_data;
    assign o_touch_irq          = st_ff.touch_irq_request;
    // Oscillators only run inside a window, so an overflow stops them as well.
    assign o_ref_osc_run        = st_ff.ref_run;
    assign o_sense_osc_run      = st_ff.sense_run;
    assign o_osc_freq_select    = st_ff.oscillator_freq_select;
    assign o_freq_double_enable = st_ff.mod_ctrl0[CTS_B_DOUBLE];
    assign o_filter_enable      = st_ff.mod_ctrl0[CTS_B_FILTER];
    assign o_hop_control_select = st_ff.mod_ctrl0[CTS_B_HOP_CTRL];
    assign o_hop_freq_select    = st_ff.mod_ctrl0[CTS_B_HOP_LSB +: 3];
    assign o_input_mux_select   = st_ff.mod_ctrl0[CTS_B_MUX_LSB +: 2];
    assign o_ref_cap_code       = st_ff.ref_cap_code;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_overflow;
        slot_ovf;
    endsequence

    sequence s_stop_write;
        start_low_wr;
    endsequence

    a_overflow_stops: assert property (
        s_overflow |=> !st_ff.running && st_ff.slot_overflow_flag && o_touch_irq)
        else $error("overflow did not stop the window");
    a_osc_stopped: assert property (
        s_overflow |=> !o_ref_osc_run && !o_sense_osc_run)
        else $error("oscillators still run after overflow");
    a_irq_only_ovf: assert property (o_touch_irq |-> $past(slot_ovf))
        else $error("interrupt without slot overflow");
    a_irq_one_cycle: assert property (o_touch_irq |=> !o_touch_irq)
        else $error("interrupt longer than one cycle");
    a_stop_clears: assert property (
        s_stop_write |=> st_ff.sense_cnt == 16'h0000 && st_ff.func_cnt == 16'h0000
                         && st_ff.unit_cnt == 5'h00)
        else $error("start low did not clear counters");
    a_slot_kept: assert property (
        s_stop_write |=> st_ff.slot_cnt == $past(st_ff.slot_cnt))
        else $error("slot counter changed on start low");
    a_counts_hold: assert property (
        !st_ff.running && !i_wr |=> $stable(st_ff.func_cnt) && $stable(st_ff.sense_cnt))
        else $error("count moved while stopped");
    a_start_rise: assert property (
        start_rise_wr |=> st_ff.running && st_ff.slot_cnt == $past(st_ff.slot_preload))
        else $error("start rise did not open a window");
    a_soft_set_ignored: assert property (
        wr_ctrl && !slot_ovf && !st_ff.slot_overflow_flag |=> !st_ff.slot_overflow_flag)
        else $error("software set the slot flag");
    a_func_gate: assert property (
        !slot_clk_sys && !ref_en && !i_wr |=> $stable(st_ff.func_cnt))
        else $error("function counter ran without a slot clock");
    a_read_refcap: assert property (
        i_rd && i_addr == CTS_OFS_REFCAP_LO |=> o_rd_data == $past(st_ff.ref_cap_code[7:0]))
        else $error("reference capacitor readback wrong");

endmodule

// [sim/cts_osc_model.sv]
// Behavioural reference and sense oscillators that face the touch scan block.
`timescale 1ns/1ps
module cts_osc_model #(
    parameter int REF_HALF   = 20,
    parameter int SENSE_HALF = 20
) (
    input  wire logic       i_ref_run,
    input  wire logic       i_sense_run,
    output logic            o_ref_osc,
    output logic      [3:0] o_sense_osc
);
    // A stopped oscillator sits low, so a block that forgets to ignore it sees no edges.
    initial
    begin
        o_ref_osc = 1'b0;
        forever #(REF_HALF) o_ref_osc = (i_ref_run === 1'b1) ? ~o_ref_osc : 1'b0;
    end
    initial
    begin
        o_sense_osc = 4'h0;
        forever #(SENSE_HALF) o_sense_osc = (i_sense_run === 1'b1) ? ~o_sense_osc : 4'h0;
    end
endmodule

// [sim/tb_top.sv]
// Self-checking testbench of the touch scan block with a register model.
`timescale 1ns/1ps
module tb_top
    import cts_pkg::*;
;
    logic              i_clk, i_rst, i_wr, i_rd, i_ref_osc;
    logic [CTS_AW-1:0] i_addr;
    logic [CTS_DW-1:0] i_wr_data, o_rd_data, r, d;
    logic [3:0]        i_sense_osc;
    logic              o_touch_irq, o_ref_osc_run, o_sense_osc_run;
    logic [1:0]        o_osc_freq_select, o_input_mux_select;
    logic              o_freq_double_enable, o_filter_enable, o_hop_control_select;
    logic [2:0]        o_hop_freq_select;
    logic [9:0]        o_ref_cap_code;
    logic [15:0]       cnt;
    int                error_cnt, compares, tmo_cnt, n;
    int                exp_reg [16];
    int                msk [16] = '{8'hff, 8'h23, 3, 0, 0, 0, 0, 8'hff, 3, 8'hff, 8'hbf,
                                    0, 0, 0, 0, 0};
    ////////////////////////////////////////////////////////////////////////////////
    cts_scan u_cts_scan (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .i_ref_osc(i_ref_osc),
        .i_sense_osc(i_sense_osc), .o_rd_data(o_rd_data), .o_touch_irq(o_touch_irq),
        .o_ref_osc_run(o_ref_osc_run), .o_sense_osc_run(o_sense_osc_run),
        .o_osc_freq_select(o_osc_freq_select), .o_freq_double_enable(o_freq_double_enable),
        .o_filter_enable(o_filter_enable), .o_hop_control_select(o_hop_control_select),
        .o_hop_freq_select(o_hop_freq_select), .o_input_mux_select(o_input_mux_select),
        .o_ref_cap_code(o_ref_cap_code));
    cts_osc_model u_cts_osc_model (.i_ref_run(o_ref_osc_run), .i_sense_run(o_sense_osc_run),
        .o_ref_osc(i_ref_osc), .o_sense_osc(i_sense_osc));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Flags only clear on a written 0; a written 1 leaves them as they were.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr      <= 1'b1;
        i_addr    <= a;
        i_wr_data <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
        exp_reg[a] = (v & msk[a]) | ((a == 1) ? (exp_reg[1] & v & 8'h58) : 0);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rd_data;
    endtask
    task automatic rd_chk(input logic [3:0] a);
        rd(a, r);
        check({8'h00, r}, 16'(exp_reg[a]));
    endtask
    task automatic scan(input logic [7:0] ctl1, input int lo, input int hi);
        wr(CTS_OFS_MOD_CTRL1, ctl1);
        wr(CTS_OFS_FUNC_CTRL, 8'h20 | 8'(exp_reg[1] & 3));
        #1;
        check({14'h0, o_ref_osc_run, o_sense_osc_run},
            {14'h0, ctl1[CTS_B_REF_EN], ctl1[CTS_B_SENSE_EN]});
        n = 0;
        while (o_touch_irq !== 1'b1 && n < 5000)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(16'(n >= lo && n <= hi), 16'h1);
        @(posedge i_clk);
        #1;
        check({14'h0, o_touch_irq, o_sense_osc_run | o_ref_osc_run}, 16'h0);
        exp_reg[1] = exp_reg[1] | 8'h40;
        rd_chk(CTS_OFS_FUNC_CTRL);
    endtask
    task automatic count_in(input logic [3:0] a, input int lo, input int hi);
        logic [7:0] l;
        rd(a, l);
        rd(a + 4'h1, r);
        cnt = {r, l};
        check(16'(cnt >= lo && cnt <= hi), 16'h1);
        repeat (20) @(posedge i_clk);
        rd(a, l);
        check({8'h0, l}, {8'h0, cnt[7:0]});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        tmo_cnt <= tmo_cnt + 1;
        if (tmo_cnt == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end
    initial
    begin
        i_rst     = 1'b1;
        i_wr      = 1'b0;
        i_rd      = 1'b0;
        i_addr    = '0;
        i_wr_data = '0;
        exp_reg   = '{default: 0};
        exp_reg[2] = 3;
        void'($urandom(32'h3560de07));
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int a = 0; a < 12; a++) rd_chk(4'(a));
        $display("test reset done");
        repeat (4)
        begin
            wr(CTS_OFS_MOD_CTRL0, 8'($urandom));
            wr(CTS_OFS_REFCAP_LO, 8'($urandom));
            wr(CTS_OFS_REFCAP_HI, 8'($urandom));
            #1;
            d = 8'(exp_reg[9]);
            check({o_input_mux_select, o_freq_double_enable, o_filter_enable,
                o_hop_control_select, o_hop_freq_select}, {8'h0, d});
            check({6'h0, o_ref_cap_code}, 16'(exp_reg[7] | (exp_reg[8] << 8)));
            for (int a = 7; a < 10; a++) rd_chk(4'(a));
        end
        for (int c = 0; c < 4; c++)
        begin
            wr(CTS_OFS_FREQ_CTRL, 8'(c) | 8'hfc);
            #1;
            check({14'h0, o_osc_freq_select}, 16'(c));
        end
        wr(CTS_OFS_SENSE_LO, 8'h5a);
        wr(4'hf, 8'ha5);
        rd_chk(CTS_OFS_SENSE_LO);
        $display("test registers done");
        wr(CTS_OFS_SLOT_PRELOAD, 8'hfe);
        wr(CTS_OFS_MOD_CTRL0, 8'h80);
        wr(CTS_OFS_FUNC_CTRL, 8'h00);
        scan(8'h94, 250, 262);
        rd_chk(CTS_OFS_MOD_CTRL1);
        count_in(CTS_OFS_FUNC_LO, 250, 262);
        count_in(CTS_OFS_SENSE_LO, 60, 66);
        $display("test system slot clock done");
        wr(CTS_OFS_FUNC_CTRL, 8'h00);
        for (int a = 1; a < 7; a++) rd_chk(4'(a));
        wr(CTS_OFS_FUNC_CTRL, 8'h40);
        rd_chk(CTS_OFS_FUNC_CTRL);
        check({15'h0, o_touch_irq}, 16'h0);
        $display("test clear done");
        wr(CTS_OFS_FUNC_CTRL, 8'h03);
        wr(CTS_OFS_SLOT_PRELOAD, 8'hff);
        scan(8'h31, 125, 135);
        count_in(CTS_OFS_FUNC_LO, 10, 17);
        count_in(CTS_OFS_SENSE_LO, 0, 0);
        $display("test reference slot clock done");
        test_done();
    end
endmodule
